//--- asr_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - write ends on first rising strobe; data timed to that edge
// - host times data setup and hold from the terminating rising edge
// - strobe write with output enable low lasts turnoff plus data setup
// - host never drives the bus while the device drives it
// - host keeps write strobe high throughout every read
// - address is valid no later than select falling in a read
// - continuous-select reads update data on address change alone
// - read cycles spaced at least 55 ns or 70 ns by grade
// - each write cycle lasts at least 55 ns or 70 ns by grade
// - write strobe stays low at least 40 ns or 50 ns by grade
// - select low at least 45 ns or 60 ns before write end
module asr_host (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic slow_grade,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [asr_pkg::ADDR_W-1:0] req_addr,
    input wire logic [asr_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [asr_pkg::DATA_W-1:0] rsp_rdata,
    output logic [asr_pkg::ADDR_W-1:0] word_address,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic output_enable_n,
    input wire logic [asr_pkg::DATA_W-1:0] shared_data_bus_in,
    output logic [asr_pkg::DATA_W-1:0] shared_data_bus_out,
    output logic shared_data_bus_oe_n
);
    asr_pkg::asr_state_e state_reg;
    logic [asr_pkg::CNT_W-1:0] cnt_reg;
    logic [asr_pkg::CNT_W-1:0] access_cyc;
    logic [asr_pkg::CNT_W-1:0] wpulse_cyc;
    logic [asr_pkg::CNT_W-1:0] wsetup_cyc;
    logic [asr_pkg::DATA_W-1:0] bus_meta_reg;
    logic [asr_pkg::DATA_W-1:0] bus_sync_reg;
    logic grade_meta_reg;
    logic grade_reg;
    logic [asr_pkg::DATA_W-1:0] wdata_reg;
    logic cnt_done;
    logic [asr_pkg::CNT_W-1:0] sel_low_cnt_reg;
    logic [asr_pkg::CNT_W-1:0] we_low_cnt_reg;
    logic [asr_pkg::CNT_W-1:0] drive_cnt_reg;
    logic [asr_pkg::CNT_W-1:0] rcyc_min;
    logic [asr_pkg::CNT_W-1:0] wcyc_min;
    logic [asr_pkg::CNT_W-1:0] wpulse_min;
    logic [asr_pkg::CNT_W-1:0] sce_min;
    logic [asr_pkg::CNT_W-1:0] setup_min;

    // bus data and the grade strap come from outside the clock domain
    always_ff @(posedge core_clk) begin
        bus_meta_reg <= shared_data_bus_in;
        bus_sync_reg <= bus_meta_reg;
        grade_meta_reg <= slow_grade;
        grade_reg <= grade_meta_reg;
    end

    // read waits access time plus two sync stages; access covers the read cycle too
    always_comb begin
        if (grade_reg) begin
            access_cyc = asr_pkg::CNT_W'(asr_pkg::ACCESS_CYC_70 + 2);
            wpulse_cyc = asr_pkg::CNT_W'(asr_pkg::SCE_CYC_70 > asr_pkg::WPULSE_70 ?
                asr_pkg::SCE_CYC_70 : asr_pkg::WPULSE_70);
            wsetup_cyc = asr_pkg::CNT_W'(asr_pkg::TURN_SETUP_CYC_70);
        end else begin
            access_cyc = asr_pkg::CNT_W'(asr_pkg::ACCESS_CYC_55 + 2);
            wpulse_cyc = asr_pkg::CNT_W'(asr_pkg::SCE_CYC_55 > asr_pkg::WPULSE_55 ?
                asr_pkg::SCE_CYC_55 : asr_pkg::WPULSE_55);
            wsetup_cyc = asr_pkg::CNT_W'(asr_pkg::TURN_SETUP_CYC_55);
        end
    end

    assign cnt_done = (cnt_reg == '0);
    assign req_ready = (state_reg == asr_pkg::ASR_IDLE);

    // write cycle: setup (we high, data driven), pulse (we low), end (we high, hold)
    // total is at least setup + pulse + 1 cycles, which covers the write cycle minimum
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= asr_pkg::ASR_IDLE;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                asr_pkg::ASR_IDLE: begin
                    if (req_valid) begin
                        state_reg <= req_write ? asr_pkg::ASR_WR_SETUP : asr_pkg::ASR_RD;
                        cnt_reg <= req_write ? wsetup_cyc - 4'h1 : access_cyc - 4'h1;
                    end
                end
                asr_pkg::ASR_RD: begin
                    if (cnt_done) begin
                        state_reg <= asr_pkg::ASR_RD_END;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                asr_pkg::ASR_RD_END: begin
                    state_reg <= asr_pkg::ASR_IDLE;
                end
                asr_pkg::ASR_WR_SETUP: begin
                    if (cnt_done) begin
                        state_reg <= asr_pkg::ASR_WR_PULSE;
                        cnt_reg <= wpulse_cyc - 4'h1;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                asr_pkg::ASR_WR_PULSE: begin
                    if (cnt_done) begin
                        state_reg <= asr_pkg::ASR_WR_END; // write strobe ends the write
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                asr_pkg::ASR_WR_END: begin
                    state_reg <= asr_pkg::ASR_IDLE;
                end
                default: begin
                    state_reg <= asr_pkg::ASR_IDLE;
                end
            endcase
        end
    end

    // pins are registered so they change together on one edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            word_address <= '0;
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            shared_data_bus_oe_n <= 1'b1;
            wdata_reg <= '0;
        end else begin
            unique case (state_reg)
                asr_pkg::ASR_IDLE: begin
                    if (req_valid) begin
                        // address set on the same edge select falls
                        word_address <= req_addr;
                        wdata_reg <= req_wdata;
                        chip_select_n <= 1'b0;
                        write_strobe_n <= 1'b1;
                        output_enable_n <= req_write;
                        // output enable is already high here, so the device floats as we drive
                        shared_data_bus_oe_n <= !req_write;
                    end
                end
                asr_pkg::ASR_RD: begin
                    if (cnt_done) begin
                        chip_select_n <= 1'b1;
                        output_enable_n <= 1'b1;
                    end
                end
                asr_pkg::ASR_WR_SETUP: begin
                    // oe stays high; drive only while the device floats
                    shared_data_bus_oe_n <= 1'b0;
                    if (cnt_done) begin
                        write_strobe_n <= 1'b0;
                    end
                end
                asr_pkg::ASR_WR_PULSE: begin
                    if (cnt_done) begin
                        write_strobe_n <= 1'b1;
                    end
                end
                asr_pkg::ASR_WR_END: begin
                    // data held one cycle past the rising strobe; select released on the same edge as the data
                    chip_select_n <= 1'b1;
                    shared_data_bus_oe_n <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    assign shared_data_bus_out = wdata_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= (state_reg == asr_pkg::ASR_RD) && cnt_done;
            if ((state_reg == asr_pkg::ASR_RD) && cnt_done) begin
                rsp_rdata <= bus_sync_reg;
            end
        end
    end

    // shortest legal phase lengths for the grade in use, read only by the checks
    always_comb begin
        if (grade_reg) begin
            rcyc_min = asr_pkg::CNT_W'(asr_pkg::READ_CYC_70);
            wcyc_min = asr_pkg::CNT_W'(asr_pkg::WCYC_70);
            wpulse_min = asr_pkg::CNT_W'(asr_pkg::WPULSE_70);
            sce_min = asr_pkg::CNT_W'(asr_pkg::SCE_CYC_70);
            setup_min = asr_pkg::CNT_W'(asr_pkg::TURN_SETUP_CYC_70);
        end else begin
            rcyc_min = asr_pkg::CNT_W'(asr_pkg::READ_CYC_55);
            wcyc_min = asr_pkg::CNT_W'(asr_pkg::WCYC_55);
            wpulse_min = asr_pkg::CNT_W'(asr_pkg::WPULSE_55);
            sce_min = asr_pkg::CNT_W'(asr_pkg::SCE_CYC_55);
            setup_min = asr_pkg::CNT_W'(asr_pkg::TURN_SETUP_CYC_55);
        end
    end

    // low time of select, write strobe and bus drive in whole cycles (not output enable); saturating, so a stuck strobe cannot wrap
    always_ff @(posedge core_clk) begin
        if (rst || chip_select_n) begin
            sel_low_cnt_reg <= '0;
        end else if (sel_low_cnt_reg != '1) begin
            sel_low_cnt_reg <= sel_low_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || write_strobe_n) begin
            we_low_cnt_reg <= '0;
        end else if (we_low_cnt_reg != '1) begin
            we_low_cnt_reg <= we_low_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || shared_data_bus_oe_n) begin
            drive_cnt_reg <= '0;
        end else if (drive_cnt_reg != '1) begin
            drive_cnt_reg <= drive_cnt_reg + 4'h1;
        end
    end

    // address and data widths come from the package

    no_contention_a: assert property (@(posedge core_clk) disable iff (rst)
        !output_enable_n |-> shared_data_bus_oe_n)
        else $error("host drives bus while output enable low");
    read_we_high_a: assert property (@(posedge core_clk) disable iff (rst)
        !output_enable_n |-> write_strobe_n)
        else $error("write strobe low during read");
    we_pulse_len_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(write_strobe_n) && grade_reg |-> !write_strobe_n [*2])
        else $error("slow grade write pulse too short");
    sel_before_end_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(write_strobe_n) |-> $past(!chip_select_n, 2))
        else $error("select not low long enough before write end");
    data_setup_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(write_strobe_n) |-> $past(!shared_data_bus_oe_n, 1))
        else $error("data not set up before write strobe");
    data_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(write_strobe_n) |-> !shared_data_bus_oe_n && !chip_select_n)
        else $error("data or select dropped with write strobe");
    addr_stable_a: assert property (@(posedge core_clk) disable iff (rst)
        !chip_select_n && $past(!chip_select_n) |-> $stable(word_address))
        else $error("address changed while selected");
    read_len_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(output_enable_n) |-> !output_enable_n [*3])
        else $error("read cycle too short");
    read_answer_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(output_enable_n) |-> ##[3:4] rsp_valid)
        else $error("read answer late");
    pulse_count_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(write_strobe_n) |-> we_low_cnt_reg >= wpulse_min)
        else $error("write pulse shorter than grade minimum");
    sce_count_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(write_strobe_n) |-> sel_low_cnt_reg >= sce_min)
        else $error("select low too briefly before write end");
    setup_count_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(write_strobe_n) |-> drive_cnt_reg >= setup_min)
        else $error("write data driven too briefly before write end");
    write_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(chip_select_n) && $past(output_enable_n) |-> sel_low_cnt_reg >= wcyc_min)
        else $error("write cycle shorter than grade minimum");
    read_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(chip_select_n) && $past(!output_enable_n) |-> sel_low_cnt_reg >= rcyc_min)
        else $error("read cycle shorter than grade minimum");
    busy_ready_a: assert property (@(posedge core_clk) disable iff (rst)
        !chip_select_n |-> !req_ready)
        else $error("request accepted while a cycle is open");
    host_drive_a: assert property (@(posedge core_clk) disable iff (rst)
        !shared_data_bus_oe_n |-> output_enable_n && !chip_select_n)
        else $error("host drives bus outside a write");
    deselect_idle_a: assert property (@(posedge core_clk) disable iff (rst)
        chip_select_n |-> write_strobe_n && output_enable_n)
        else $error("strobe active while deselected");
    rsp_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        rsp_valid |=> !rsp_valid)
        else $error("read answer longer than one cycle");
    // captured word was sampled two edges before capture, behind the sync stages
    access_wait_a: assert property (@(posedge core_clk) disable iff (rst)
        rsp_valid |-> $past(sel_low_cnt_reg) >= asr_pkg::CNT_W'(asr_pkg::ACCESS_CYC_70 + 1))
        else $error("read data captured before access time");
    rdata_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        !rsp_valid |-> $stable(rsp_rdata))
        else $error("read data changed without an answer");
endmodule : asr_host

//--- asr_pkg.sv
package asr_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 50;
    // minimum durations in ns, faster grade then slower grade
    localparam int READ_CYCLE_MIN_55_NS = 55;
    localparam int READ_CYCLE_MIN_70_NS = 70;
    localparam int ADDRESS_ACCESS_TIME_55_NS = 55;
    localparam int ADDRESS_ACCESS_TIME_70_NS = 70;
    localparam int WRITE_CYCLE_MIN_55_NS = 55;
    localparam int WRITE_CYCLE_MIN_70_NS = 70;
    localparam int WRITE_PULSE_MIN_55_NS = 40;
    localparam int WRITE_PULSE_MIN_70_NS = 50;
    localparam int SELECT_TO_WRITE_END_MIN_55_NS = 45;
    localparam int SELECT_TO_WRITE_END_MIN_70_NS = 60;
    localparam int WRITE_TURNOFF_DELAY_55_NS = 20;
    localparam int WRITE_TURNOFF_DELAY_70_NS = 25;
    localparam int WRITE_DATA_SETUP_55_NS = 25;
    localparam int WRITE_DATA_SETUP_70_NS = 30;
    // round up, never below one cycle
    function automatic int cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc
    localparam int READ_CYC_55 = cyc(READ_CYCLE_MIN_55_NS);
    localparam int READ_CYC_70 = cyc(READ_CYCLE_MIN_70_NS);
    localparam int ACCESS_CYC_55 = cyc(ADDRESS_ACCESS_TIME_55_NS);
    localparam int ACCESS_CYC_70 = cyc(ADDRESS_ACCESS_TIME_70_NS);
    localparam int WCYC_55 = cyc(WRITE_CYCLE_MIN_55_NS);
    localparam int WCYC_70 = cyc(WRITE_CYCLE_MIN_70_NS);
    localparam int WPULSE_55 = cyc(WRITE_PULSE_MIN_55_NS);
    localparam int WPULSE_70 = cyc(WRITE_PULSE_MIN_70_NS);
    localparam int SCE_CYC_55 = cyc(SELECT_TO_WRITE_END_MIN_55_NS);
    localparam int SCE_CYC_70 = cyc(SELECT_TO_WRITE_END_MIN_70_NS);
    localparam int TURN_SETUP_CYC_55 = cyc(WRITE_TURNOFF_DELAY_55_NS + WRITE_DATA_SETUP_55_NS);
    localparam int TURN_SETUP_CYC_70 = cyc(WRITE_TURNOFF_DELAY_70_NS + WRITE_DATA_SETUP_70_NS);
    localparam int CNT_W = 4;
    typedef enum logic [2:0] {
        ASR_IDLE = 3'b000,
        ASR_RD = 3'b001,
        ASR_RD_END = 3'b010,
        ASR_WR_SETUP = 3'b011,
        ASR_WR_PULSE = 3'b100,
        ASR_WR_END = 3'b101
    } asr_state_e;
endpackage : asr_pkg

//--- asr_sram_model.sv
`timescale 1ns/1ps
module asr_sram_model #(
    parameter int ACCESS_NS = 70
) (
    input wire logic [asr_pkg::ADDR_W-1:0] word_address,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [asr_pkg::DATA_W-1:0] bus,
    output logic [asr_pkg::DATA_W-1:0] dev_out,
    output logic dev_drive
);
    logic [asr_pkg::DATA_W-1:0] mem [0:32767];
    // select rising with the strobe never opens a drive window
    assign dev_drive = !chip_select_n && write_strobe_n && !output_enable_n;
    // last value seen inside the overlap is what stays stored
    always @* begin
        if (!chip_select_n && !write_strobe_n) begin
            mem[word_address] = bus;
        end
    end
    // stale word shows until the access time runs out
    assign #(ACCESS_NS) dev_out = mem[word_address];
endmodule : asr_sram_model

//--- async_sram_port_timing_tb.sv
`timescale 1ns/1ps
module async_sram_port_timing_tb;
    logic core_clk, rst, slow_grade, req_valid, req_write, rsp_valid, req_ready;
    logic chip_select_n, write_strobe_n, output_enable_n, shared_data_bus_oe_n, dev_drive;
    logic [asr_pkg::ADDR_W-1:0] req_addr, word_address;
    logic [asr_pkg::DATA_W-1:0] req_wdata, rsp_rdata, shared_data_bus_out, dev_out, bus;
    logic [asr_pkg::DATA_W-1:0] float_val = 8'h5a;
    logic [asr_pkg::DATA_W-1:0] rd;
    int n_mismatch = 0;
    int samples_checked = 0;
    // grade in bit 24, word address in bits 22:8, data in bits 7:0
    logic [27:0] rows [0:5] = '{28'h0_0000_a5, 28'h0_7fff_3c, 28'h0_1234_ff,
        28'h1_0001_00, 28'h1_7ffe_c3, 28'h1_5555_69};
    // released bus shows a toggling pattern, never the last level
    assign bus = !shared_data_bus_oe_n ? shared_data_bus_out : dev_drive ? dev_out : float_val;
    always @(posedge core_clk) float_val <= ~bus;
    asr_host asr_host_inst (.core_clk(core_clk), .rst(rst), .slow_grade(slow_grade),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .word_address(word_address), .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
        .shared_data_bus_in(bus), .shared_data_bus_out(shared_data_bus_out),
        .shared_data_bus_oe_n(shared_data_bus_oe_n));
    asr_sram_model asr_sram_model_inst (.word_address(word_address),
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_enable_n(output_enable_n), .bus(bus), .dev_out(dev_out),
        .dev_drive(dev_drive));
    task automatic stop_test;
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check
    // one request; reads also return data and check the answer latency in cycles
    task automatic do_req(input logic wr, input logic [14:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        @(negedge core_clk);
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        @(posedge core_clk);
        while (req_ready !== 1'b1) begin
            n++;
            if (n > 40) begin
                n_mismatch++;
                stop_test();
            end
            @(posedge core_clk);
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 1;
        if (!wr) begin
            while (rsp_valid !== 1'b1 && n < 40) begin
                @(negedge core_clk);
                n++;
            end
            check(n == 5, "read answer latency");
            q = rsp_rdata;
            if (n >= 40) begin
                stop_test();
            end
        end
    endtask : do_req
    // contention watch on every rising edge
    always @(posedge core_clk) begin
        if (!rst && shared_data_bus_oe_n === 1'b0 && dev_drive === 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: bus contention", $time);
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        rst = 1'b1;
        slow_grade = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        repeat (6) @(negedge core_clk);
        check(chip_select_n === 1'b1 && write_strobe_n === 1'b1, "strobes at reset");
        check(shared_data_bus_oe_n === 1'b1 && word_address === 15'h0000, "idle at reset");
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        for (int i = 0; i < 6; i++) begin
            slow_grade = rows[i][24];
            repeat (3) @(negedge core_clk);
            do_req(1'b1, rows[i][22:8], rows[i][7:0], rd);
        end
        for (int i = 0; i < 6; i++) begin
            slow_grade = rows[i][24];
            repeat (3) @(negedge core_clk);
            do_req(1'b0, rows[i][22:8], 8'h00, rd);
            check(rd === rows[i][7:0], "read back value");
        end
        // back-to-back overwrite then read of the same word
        do_req(1'b1, 15'h7fff, 8'h81, rd);
        do_req(1'b1, 15'h7fff, 8'h18, rd);
        do_req(1'b0, 15'h7fff, 8'h00, rd);
        check(rd === 8'h18, "overwrite read");
        // reset in the middle of a write leaves the word untouched when aborted early
        @(negedge core_clk);
        req_write = 1'b1;
        req_addr = 15'h0000;
        req_wdata = 8'he7;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        rst = 1'b1;
        @(negedge core_clk);
        @(negedge core_clk);
        check(chip_select_n === 1'b1 && shared_data_bus_oe_n === 1'b1, "abort release");
        check(rsp_valid === 1'b0, "no answer after abort");
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        do_req(1'b0, 15'h0000, 8'h00, rd);
        check(rd === 8'ha5, "aborted write ignored");
        stop_test();
    end
endmodule : async_sram_port_timing_tb
